// *** rtl/system_reset_control.sv ***
/*
 * System reset controller: merges supply, pin, low-voltage and watchdog sources
 * into one synchronously released system reset and drives reset defaults.
 * Assumes all inputs are synchronous to I_REF_CLK and the pad resolves the
 * pin from O_EXT_RESET_PIN_N_OE (low = drive low).
 */
`timescale 1ns/10ps
`default_nettype none
`include "rst_ctrl_params.svh"

module system_reset_control (
    input wire logic I_REF_CLK,
    input wire logic I_SRST,
    input wire logic I_POWER_ON_OFF,
    input wire logic I_EXT_RESET_PIN_N,
    input wire logic I_LOW_VOLTAGE_DETECT,
    input wire logic I_LV_RESET_EN_WR,
    input wire logic I_LV_RESET_EN_DATA,
    input wire logic I_WATCHDOG_TIMEOUT_RESET,
    input wire rst_ctrl_pkg::power_mode_t I_POWER_MODE,
    output logic O_EXT_RESET_PIN_N_OUT,
    output logic O_EXT_RESET_PIN_N_OE,
    output logic O_SYS_RESET,
    output logic O_PC_LOAD_STB,
    output rst_ctrl_pkg::reset_defaults_t O_DEFAULTS,
    output rst_ctrl_pkg::reset_cause_t O_RESET_CAUSE,
    output logic O_INTERNAL_OSC_EN
);
    import rst_ctrl_pkg::*;

    localparam logic [`SYNC_CNT_W-1:0] SYNC_LAST = `SYNC_CNT_W'(`SYNC_RESET_LEN - 1);

    function automatic logic osc_needed(input power_mode_t m);
        osc_needed = (m != PM_STOP) && (m != PM_SLEEP);
    endfunction

    logic pin_low_ok;
    reset_cause_t cause_now;
    logic any_src;
    logic lv_reset_hit;

    rst_state_t st_q;
    rst_state_t st_d;
    logic [`SYNC_CNT_W-1:0] cnt_q;
    logic [`SYNC_CNT_W-1:0] cnt_d;
    logic lv_reset_en_q;
    logic lv_reset_en_d;
    reset_cause_t cause_q;
    reset_cause_t cause_d;
    logic pc_stb_q;
    logic pc_stb_d;
    logic drive_q;
    logic drive_d;
    logic osc_q;
    logic osc_d;

    pin_filter pin_filter_i (
        .i_clk(I_REF_CLK),
        .i_srst(I_SRST),
        .i_pin_n(I_EXT_RESET_PIN_N),
        .o_low_ok(pin_low_ok)
    );

    // While the device itself pulls the pin low the filter would see its own drive;
    // that is harmless because a supply or low-voltage reset is already active then.
    assign lv_reset_hit = lv_reset_en_q && I_LOW_VOLTAGE_DETECT;
    always_comb begin
        cause_now.power_on_off = I_POWER_ON_OFF;
        cause_now.ext_reset_pin = pin_low_ok;
        cause_now.low_voltage_reset = lv_reset_hit;
        cause_now.watchdog_timeout_reset = I_WATCHDOG_TIMEOUT_RESET;
    end
    assign any_src = |cause_now;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        lv_reset_en_d = lv_reset_en_q;
        cause_d = cause_q;
        pc_stb_d = 1'b0;
        drive_d = I_POWER_ON_OFF || lv_reset_hit;
        osc_d = osc_needed(I_POWER_MODE);
        case (st_q)
            ST_RESET: begin
                cnt_d = '0;
                lv_reset_en_d = `LV_RESET_EN_DEFAULT;
                osc_d = 1'b1;
                if (!any_src) begin
                    st_d = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                lv_reset_en_d = `LV_RESET_EN_DEFAULT;
                osc_d = 1'b1;
                if (any_src) begin
                    st_d = ST_RESET;
                end else if (cnt_q == SYNC_LAST) begin
                    st_d = ST_RUN;
                    pc_stb_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + `SYNC_CNT_W'(1);
                end
            end
            ST_RUN: begin
                if (I_LV_RESET_EN_WR) begin
                    lv_reset_en_d = I_LV_RESET_EN_DATA;
                end
                if (any_src) begin
                    st_d = ST_RESET;
                    cause_d = cause_now;
                    // Entered from stop or sleep, the oscillator must run in the first reset cycle.
                    osc_d = 1'b1;
                end
            end
            default: begin
                st_d = ST_RESET;
            end
        endcase
        if (any_src && st_q != ST_RUN) begin
            cause_d = cause_q | cause_now;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            st_q <= ST_RESET;
            cnt_q <= '0;
            lv_reset_en_q <= `LV_RESET_EN_DEFAULT;
            cause_q <= '0;
            pc_stb_q <= 1'b0;
            drive_q <= 1'b0;
            osc_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            lv_reset_en_q <= lv_reset_en_d;
            cause_q <= cause_d;
            pc_stb_q <= pc_stb_d;
            drive_q <= drive_d;
            osc_q <= osc_d;
        end
    end

    assign O_SYS_RESET = (st_q != ST_RUN);
    assign O_EXT_RESET_PIN_N_OUT = 1'b0;
    assign O_EXT_RESET_PIN_N_OE = !drive_q;
    assign O_PC_LOAD_STB = pc_stb_q;
    assign O_RESET_CAUSE = cause_q;
    assign O_INTERNAL_OSC_EN = osc_q;
    always_comb begin
        O_DEFAULTS.pc_load = `RESET_VECTOR;
        O_DEFAULTS.watchdog_sel = `WATCHDOG_SEL_MAX;
        O_DEFAULTS.watchdog_enable = 1'b1;
        O_DEFAULTS.clk_sel = `CLK_SEL_INTERNAL;
        O_DEFAULTS.lv_reset_enable = lv_reset_en_q;
    end

    sequence s_sources_gone;
        !any_src [*4];
    endsequence

    a_src_gives_reset: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        any_src |=> O_SYS_RESET)
        else $error("a reset source did not raise system reset");
    // Cause bits only accumulate while reset is active; an entry from run replaces them.
    a_cause_recorded: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        any_src |=> (O_RESET_CAUSE | $past(cause_now, 1)) == O_RESET_CAUSE)
        else $error("reset cause not recorded");
    a_release_sync: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        (st_q == ST_RESET && !any_src) ##1 s_sources_gone |=> !O_SYS_RESET)
        else $error("reset not released after quiet sources");
    a_no_early_release: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        $fell(O_SYS_RESET) |-> $past(st_q, 1) == ST_RELEASE && $past(!any_src, 2))
        else $error("reset released without the release interval");
    a_pc_on_release: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        $fell(O_SYS_RESET) |-> O_PC_LOAD_STB && O_DEFAULTS.pc_load == 20'h07000)
        else $error("program counter not loaded with reset vector");
    a_pc_single: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        O_PC_LOAD_STB |=> !O_PC_LOAD_STB)
        else $error("program counter load strobe longer than one cycle");
    a_pc_only_release: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        O_PC_LOAD_STB |-> !O_SYS_RESET && $past(O_SYS_RESET, 1))
        else $error("program counter load outside the release edge");
    a_pin_drive: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        I_POWER_ON_OFF |=> !O_EXT_RESET_PIN_N_OE)
        else $error("pin not driven low during supply reset");
    a_lv_pin_drive: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        lv_reset_hit |=> !O_EXT_RESET_PIN_N_OE && !O_EXT_RESET_PIN_N_OUT)
        else $error("pin not driven low during low-voltage reset");
    a_lv_reset_off: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        O_SYS_RESET && $past(O_SYS_RESET, 1) |-> !lv_reset_en_q)
        else $error("low-voltage reset enabled during reset");
    // Software cannot arm the detector while reset is still active.
    a_lv_write_refused: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        O_SYS_RESET && I_LV_RESET_EN_WR |=> !lv_reset_en_q)
        else $error("low-voltage reset enable written during reset");
    a_watchdog_defaults: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        O_SYS_RESET |-> O_DEFAULTS.watchdog_enable
            && O_DEFAULTS.watchdog_sel == 2'h3)
        else $error("watchdog not at maximum timeout in reset");
    a_osc_modes: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        !O_SYS_RESET && $past(!O_SYS_RESET, 1) |->
        O_INTERNAL_OSC_EN == ($past(I_POWER_MODE, 1) != PM_STOP
            && $past(I_POWER_MODE, 1) != PM_SLEEP))
        else $error("oscillator enable does not follow power mode");
    a_clk_internal: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        O_SYS_RESET |-> O_DEFAULTS.clk_sel == 1'b0 && O_INTERNAL_OSC_EN)
        else $error("internal oscillator not selected in reset");
endmodule

`default_nettype wire

// *** common/rst_ctrl_params.svh ***
/*
 * Constants for the system reset controller: vector, defaults and timing counts.
 * Assumes a 25 MHz reference clock; included by the package and design files.
 */
`ifndef RST_CTRL_PARAMS_SVH
`define RST_CTRL_PARAMS_SVH

`define CLK_PERIOD_NS 40
`define PIN_FILTER_NS 5000
// Least time: a low shorter than this is ignored, so the count rounds up.
`define PIN_FILTER_CYC ((`PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_HOLD_NS 50000
`define PIN_HOLD_CYC ((`PIN_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_CNT_W 8
`define RESET_VECTOR 20'h07000
`define PC_W 20
`define WATCHDOG_SEL_W 2
`define WATCHDOG_SEL_MAX 2'h3
`define LV_RESET_EN_DEFAULT 1'h0
`define CLK_SEL_INTERNAL 1'h0
`define SYNC_RESET_LEN 4
`define SYNC_CNT_W 3

`endif

// *** common/rst_ctrl_pkg.sv ***
/*
 * Types shared by the reset controller and its pin filter.
 * Assumes the params header is reachable on the include path.
 */
`include "rst_ctrl_params.svh"

package rst_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_RELEASE = 2'h1,
        ST_RUN = 2'h3
    } rst_state_t;

    typedef enum logic [1:0] {
        PM_NORMAL = 2'h0,
        PM_IDLE = 2'h1,
        PM_STOP = 2'h2,
        PM_SLEEP = 2'h3
    } power_mode_t;

    typedef struct packed {
        logic power_on_off;
        logic ext_reset_pin;
        logic low_voltage_reset;
        logic watchdog_timeout_reset;
    } reset_cause_t;

    typedef struct packed {
        logic [`PC_W-1:0] pc_load;
        logic [`WATCHDOG_SEL_W-1:0] watchdog_sel;
        logic watchdog_enable;
        logic clk_sel;
        logic lv_reset_enable;
    } reset_defaults_t;
endpackage

// *** rtl/pin_filter.sv ***
/*
 * Glitch filter for the active-low external reset pin.
 * Assumes the pin has already been brought into the reference clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rst_ctrl_params.svh"

module pin_filter (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_pin_n,
    output logic o_low_ok
);
    import rst_ctrl_pkg::*;

    logic [`FILT_CNT_W-1:0] cnt_q;
    logic [`FILT_CNT_W-1:0] cnt_d;
    logic ok_q;
    logic ok_d;

    localparam logic [`FILT_CNT_W-1:0] FILT_LAST = `FILT_CNT_W'(`PIN_FILTER_CYC - 1);

    // A low must last the whole filter window; any high restarts the count.
    always_comb begin
        cnt_d = cnt_q;
        ok_d = ok_q;
        if (i_pin_n) begin
            cnt_d = '0;
            ok_d = 1'b0;
        end else if (cnt_q != FILT_LAST) begin
            cnt_d = cnt_q + `FILT_CNT_W'(1);
        end else begin
            ok_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_q <= '0;
            ok_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ok_q <= ok_d;
        end
    end

    assign o_low_ok = ok_q;

    a_short_low_ignored: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(ok_q) |-> $past(!i_pin_n, 1) && cnt_q == FILT_LAST)
        else $error("filter accepted a low before the window ended");
    a_high_clears_filter: assert property (@(posedge i_clk) disable iff (i_srst)
        i_pin_n |=> !ok_q && cnt_q == '0)
        else $error("filter kept a low after the pin went high");
endmodule

`default_nettype wire

// *** bench/reset_pin_model.sv ***
/*
 * Model of the reset pin circuit and the supply monitors.
 * Assumes the bench sets its controls just after a clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module reset_pin_model (
    input wire logic i_press,
    input wire logic i_power_fail,
    input wire logic i_low_volt,
    input wire logic i_drive_oe,
    input wire logic i_drive_val,
    output logic o_pin_n,
    output logic o_power_on_off,
    output logic o_low_voltage_detect
);
    // The pin has a pull-up, so it reads high unless the button or the device pulls it.
    assign o_pin_n = !(i_press || (!i_drive_oe && !i_drive_val));
    assign o_power_on_off = i_power_fail;
    assign o_low_voltage_detect = i_low_volt;
endmodule

`default_nettype wire

// *** bench/system_reset_control_tb.sv ***
/*
 * Self-checking bench for the system reset controller.
 * Assumes the pin model above and a 25 MHz reference clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rst_ctrl_params.svh"

module system_reset_control_tb;
    import rst_ctrl_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic press = 1'b0;
    logic pfail = 1'b0;
    logic low_volt = 1'b0;
    logic wr = 1'b0;
    logic wr_data = 1'b0;
    logic wdog = 1'b0;
    power_mode_t mode = PM_NORMAL;
    logic pin_n;
    logic pon;
    logic lv;
    logic pin_oe;
    logic pin_out;
    logic sys_rst;
    logic pc_stb;
    logic osc_en;
    reset_defaults_t defs;
    reset_cause_t cause;
    int n_mismatch = 0;
    int checks_done = 0;

    always #20 clk = ~clk;

    reset_pin_model reset_pin_model_i (.i_press(press), .i_power_fail(pfail),
        .i_low_volt(low_volt), .i_drive_oe(pin_oe), .i_drive_val(pin_out), .o_pin_n(pin_n),
        .o_power_on_off(pon), .o_low_voltage_detect(lv));

    system_reset_control system_reset_control_i (.I_REF_CLK(clk), .I_SRST(srst),
        .I_POWER_ON_OFF(pon), .I_EXT_RESET_PIN_N(pin_n), .I_LOW_VOLTAGE_DETECT(lv),
        .I_LV_RESET_EN_WR(wr), .I_LV_RESET_EN_DATA(wr_data),
        .I_WATCHDOG_TIMEOUT_RESET(wdog), .I_POWER_MODE(mode),
        .O_EXT_RESET_PIN_N_OUT(pin_out), .O_EXT_RESET_PIN_N_OE(pin_oe), .O_SYS_RESET(sys_rst),
        .O_PC_LOAD_STB(pc_stb), .O_DEFAULTS(defs), .O_RESET_CAUSE(cause),
        .O_INTERNAL_OSC_EN(osc_en));

    task tick;
        @(posedge clk);
        #1;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Every release must come out with the full set of defaults.
    task wait_release;
        int k;
        k = 0;
        while (k < 200 && sys_rst !== 1'b0) begin
            tick;
            k++;
        end
        check(sys_rst, 1'b0);
        check(pc_stb, 1'b1);
        check(defs.pc_load, 20'h07000);
        check(defs.watchdog_sel, `WATCHDOG_SEL_MAX);
        check(defs.watchdog_enable, 1'b1);
        check(defs.clk_sel, `CLK_SEL_INTERNAL);
        check(defs.lv_reset_enable, 1'b0);
        tick;
        check(pc_stb, 1'b0);
    endtask

    task run_osc;
        for (int m = 0; m < 4; m++) begin
            mode = power_mode_t'(m[1:0]);
            tick;
            check(osc_en, m < 2);
        end
        mode = PM_NORMAL;
        tick;
    endtask

    // The bench holds the button for n edges; a sure reset uses 50 us.
    task run_pin(input int n, input logic exp);
        logic seen;
        seen = 1'b0;
        press = 1'b1;
        for (int k = 0; k < n; k++) begin
            tick;
            seen |= sys_rst;
        end
        check(seen, exp);
        check(pin_oe, 1'b1);
        if (exp)
            check(cause.ext_reset_pin, 1'b1);
        press = 1'b0;
        repeat (3) tick;
        if (exp)
            wait_release;
        else
            check(sys_rst, 1'b0);
    endtask

    task run_power;
        pfail = 1'b1;
        tick;
        check(sys_rst, 1'b1);
        check(pin_oe, 1'b0);
        tick;
        check(cause.power_on_off, 1'b1);
        check(pin_n, 1'b0);
        check(pin_out, 1'b0);
        pfail = 1'b0;
        repeat (3) tick;
        check(sys_rst, 1'b1);
        wait_release;
    endtask

    task run_low_volt;
        low_volt = 1'b1;
        repeat (3) tick;
        check(sys_rst, 1'b0);
        low_volt = 1'b0;
        wr = 1'b1;
        wr_data = 1'b1;
        tick;
        wr = 1'b0;
        check(defs.lv_reset_enable, 1'b1);
        low_volt = 1'b1;
        tick;
        check(sys_rst, 1'b1);
        check(pin_oe, 1'b0);
        low_volt = 1'b0;
        tick;
        check(cause.low_voltage_reset, 1'b1);
        wait_release;
    endtask

    // A write that lands during reset must be refused; the reset starts from stop mode.
    task run_wdog;
        mode = PM_STOP;
        tick;
        check(osc_en, 1'b0);
        wdog = 1'b1;
        tick;
        wdog = 1'b0;
        check(sys_rst, 1'b1);
        check(pin_oe, 1'b1);
        check(osc_en, 1'b1);
        wr = 1'b1;
        mode = PM_NORMAL;
        tick;
        wr = 1'b0;
        check(cause.watchdog_timeout_reset, 1'b1);
        wait_release;
    endtask

    // A mid-run reset must clear the cause and the detector enable.
    task run_srst;
        wr = 1'b1;
        tick;
        wr = 1'b0;
        check(defs.lv_reset_enable, 1'b1);
        srst = 1'b1;
        tick;
        srst = 1'b0;
        check(sys_rst, 1'b1);
        check(cause, 4'h0);
        check(defs.lv_reset_enable, 1'b0);
        wait_release;
    endtask

    initial begin
        repeat (8) tick;
        srst = 1'b0;
        wait_release;
        run_osc;
        run_pin(`PIN_FILTER_CYC - 1, 1'b0);
        run_pin(`PIN_HOLD_CYC, 1'b1);
        run_power;
        run_low_volt;
        run_wdog;
        run_srst;
        complete_run;
    end

    initial begin
        #200000;
        n_mismatch++;
        complete_run;
    end
endmodule

`default_nettype wire
